// ### clock_strap_pkg.sv
// Constants shared by the strap-decoding clock control block
package clock_strap_pkg;

   // ----------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------
   localparam logic [11:0] OFFSET_STATUS = 12'h000;
   localparam logic [11:0] OFFSET_CTRL = 12'h004;

   // ----------------------------------------
   // Status and control field positions
   // ----------------------------------------
   localparam int POS_RATIO_CODE = 0;
   localparam int POS_RATIO_HALF = 4;
   localparam int POS_VCO_MULT = 8;
   localparam int POS_BYPASS = 12;
   localparam int POS_CLOCK_STOP = 13;
   localparam int POS_HYST_ON = 14;
   localparam int POS_CORE_CLOCK_OUTPUT_EN = 15;
   localparam int POS_FAST_OUT = 16;
   localparam int POS_VALID = 17;
   localparam int POS_MODE_HOLD = 0;

   // ----------------------------------------
   // Ratio strap codes
   // ----------------------------------------
   localparam logic [3:0] CODE_X8 = 4'h1;
   localparam logic [3:0] CODE_BYPASS = 4'h3;
   localparam logic [3:0] CODE_CLOCK_OFF = 4'hF;

   // Ratio in half steps (2 means 1:1, 14 means 7:1)
   localparam logic [3:0] HALF_1_TO_1 = 4'h2;
   localparam logic [3:0] HALF_MAX = 4'hE;
   localparam logic [3:0] HALF_NONE = 4'h0;
   localparam logic [3:0] VCO_X2 = 4'h2;
   localparam logic [3:0] VCO_X8 = 4'h8;

   // ----------------------------------------
   // Values after reset
   // ----------------------------------------
   localparam logic [3:0] RST_RATIO_CODE = 4'h0;
   localparam logic [1:0] RST_SAMPLE = 2'h3;
   localparam logic RST_MODE_HOLD = 1'b0;
   // Synchronised hard reset reads released, so reset alone starts no frame
   localparam logic [6:0] RST_PIN_SYNC = 7'h40;

   typedef enum logic [1:0] {WAIT_ASSERT, SAMPLE_LOW, DECODE} strap_state_type;

endpackage

// ### clock_strap_select.sv
// Strap decoder for core clock ratio, PLL mode and I/O modes, with APB status
`timescale 1ns/1ps

// What this block does
// - Decode the four-bit ratio strap into a 1:1 to 7:1 ratio in half steps, except code 1111 which stops the core clock; VCO x2 except code 0001 at x8.
// - Code 0011 bypasses the PLL, clocks the core from the bus clock and runs the bus at 1:1.
// - Input-mode strap tied to supply gives hysteresis off and a driven clock output.
// - Input-mode strap tied to ground gives hysteresis on and a high impedance clock output.
// - Input-mode strap wired to hard reset gives hysteresis on and a driven clock output.
// - Input-mode strap wired to inverted hard reset gives hysteresis off and a floating clock output.
// - Output-mode strap at ground or on hard reset selects fast-output timing.
// - Output-mode strap at supply or on inverted hard reset keeps compatibility timing.
module clock_strap_select
   import clock_strap_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] ratioStrap,
   input wire logic inputModeStrap,
   input wire logic outputModeStrap,
   input wire logic hardResetN,
   output logic [3:0] ratioHalf,
   output logic [3:0] vcoMultiplier,
   output logic pllEnable,
   output logic pllBypass,
   output logic busOneToOne,
   output logic coreClockStop,
   output logic hysteresisOn,
   output logic coreClockOutputEnable,
   output logic fastOutputMode,
   output logic configValid
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [6:0] pinMeta;
   logic [6:0] pinSync;
   logic [3:0] ratioSync;
   logic inputSync;
   logic outputSync;
   logic hardResetSyncN;

   // Two flops on every strap pin and on hard reset
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pinMeta <= RST_PIN_SYNC;
         pinSync <= RST_PIN_SYNC;
      end else begin
         pinMeta <= {hardResetN, outputModeStrap, inputModeStrap, ratioStrap};
         pinSync <= pinMeta;
      end
   end

   assign ratioSync = pinSync[3:0];
   assign inputSync = pinSync[4];
   assign outputSync = pinSync[5];
   assign hardResetSyncN = pinSync[6];

   // ----------------------------------------
   // Ratio decode
   // ----------------------------------------
   function automatic logic [3:0] halfRatioOf(input logic [3:0] code);
      case (code)
         4'h0: halfRatioOf = 4'h2;
         4'h1: halfRatioOf = 4'h2;
         4'hC: halfRatioOf = 4'h3;
         4'h4: halfRatioOf = 4'h4;
         4'h6: halfRatioOf = 4'h5;
         4'h8: halfRatioOf = 4'h6;
         4'hE: halfRatioOf = 4'h7;
         4'hA: halfRatioOf = 4'h8;
         4'h7: halfRatioOf = 4'h9;
         4'hB: halfRatioOf = 4'hA;
         4'h9: halfRatioOf = 4'hB;
         4'hD: halfRatioOf = 4'hC;
         4'h5: halfRatioOf = 4'hD;
         4'h2: halfRatioOf = 4'hE;
         4'h3: halfRatioOf = HALF_1_TO_1;
         default: halfRatioOf = HALF_NONE;
      endcase
   endfunction

   // ----------------------------------------
   // Strap capture state
   // ----------------------------------------
   strap_state_type state;
   strap_state_type next_state;
   logic [1:0] lowSample;
   logic [1:0] next_lowSample;
   logic [3:0] ratioCode;
   logic [3:0] next_ratioCode;
   logic [3:0] next_ratioHalf;
   logic [3:0] next_vcoMultiplier;
   logic next_pllEnable;
   logic next_pllBypass;
   logic next_busOneToOne;
   logic next_coreClockStop;
   logic next_hysteresisOn;
   logic next_coreClockOutputEnable;
   logic next_fastOutputMode;
   logic next_configValid;
   logic modeHold;
   logic next_modeHold;

   // Sample during reset, then decode at release
   always_comb begin
      next_state = state;
      next_lowSample = lowSample;
      next_ratioCode = ratioCode;
      next_ratioHalf = ratioHalf;
      next_vcoMultiplier = vcoMultiplier;
      next_pllEnable = pllEnable;
      next_pllBypass = pllBypass;
      next_busOneToOne = busOneToOne;
      next_coreClockStop = coreClockStop;
      next_hysteresisOn = hysteresisOn;
      next_coreClockOutputEnable = coreClockOutputEnable;
      next_fastOutputMode = fastOutputMode;
      next_configValid = configValid;
      case (state)
         WAIT_ASSERT: begin
            if (!hardResetSyncN && !modeHold) begin
               next_state = SAMPLE_LOW;
            end
         end
         SAMPLE_LOW: begin
            // Release edge already carries the after-release levels: keep the last low one
            if (!hardResetSyncN) begin
               next_lowSample = {outputSync, inputSync};
            end else begin
               next_state = DECODE;
            end
         end
         DECODE: begin
            // Low sample versus level now: reset-wired strap reads 0 then 1
            next_hysteresisOn = !lowSample[0];
            next_coreClockOutputEnable = inputSync;
            next_fastOutputMode = !lowSample[1];
            next_ratioCode = ratioSync;
            next_ratioHalf = halfRatioOf(ratioSync);
            next_vcoMultiplier = (ratioSync == CODE_X8) ? VCO_X8 : VCO_X2;
            next_pllBypass = (ratioSync == CODE_BYPASS);
            next_busOneToOne = (ratioSync == CODE_BYPASS);
            next_coreClockStop = (ratioSync == CODE_CLOCK_OFF);
            next_pllEnable = (ratioSync != CODE_BYPASS) && (ratioSync != CODE_CLOCK_OFF);
            next_configValid = 1'b1;
            next_state = WAIT_ASSERT;
         end
         default: begin
            next_state = WAIT_ASSERT;
         end
      endcase
   end

   // Register the capture state and decoded modes
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         // Wait for a real frame; reset flops are no strap samples
         state <= WAIT_ASSERT;
         lowSample <= RST_SAMPLE;
         ratioCode <= RST_RATIO_CODE;
         ratioHalf <= HALF_1_TO_1;
         vcoMultiplier <= VCO_X2;
         pllEnable <= 1'b1;
         pllBypass <= 1'b0;
         busOneToOne <= 1'b0;
         coreClockStop <= 1'b0;
         hysteresisOn <= 1'b0;
         coreClockOutputEnable <= 1'b1;
         fastOutputMode <= 1'b0;
         configValid <= 1'b0;
      end else begin
         state <= next_state;
         lowSample <= next_lowSample;
         ratioCode <= next_ratioCode;
         ratioHalf <= next_ratioHalf;
         vcoMultiplier <= next_vcoMultiplier;
         pllEnable <= next_pllEnable;
         pllBypass <= next_pllBypass;
         busOneToOne <= next_busOneToOne;
         coreClockStop <= next_coreClockStop;
         hysteresisOn <= next_hysteresisOn;
         coreClockOutputEnable <= next_coreClockOutputEnable;
         fastOutputMode <= next_fastOutputMode;
         configValid <= next_configValid;
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   logic [31:0] statusWord;
   logic [31:0] next_prdata;
   logic mapped;

   // Status word from the decoded state
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[POS_RATIO_CODE +: 4] = ratioCode;
      statusWord[POS_RATIO_HALF +: 4] = ratioHalf;
      statusWord[POS_VCO_MULT +: 4] = vcoMultiplier;
      statusWord[POS_BYPASS] = pllBypass;
      statusWord[POS_CLOCK_STOP] = coreClockStop;
      statusWord[POS_HYST_ON] = hysteresisOn;
      statusWord[POS_CORE_CLOCK_OUTPUT_EN] = coreClockOutputEnable;
      statusWord[POS_FAST_OUT] = fastOutputMode;
      statusWord[POS_VALID] = configValid;
   end

   assign mapped = (paddr == OFFSET_STATUS) || (paddr == OFFSET_CTRL);
   assign pready = 1'b1; // Zero wait states
   assign pslverr = psel && penable && !mapped;

   // Read data latched in setup, hold bit written in access
   always_comb begin
      next_prdata = prdata;
      next_modeHold = modeHold;
      if (psel && !penable) begin
         if (paddr == OFFSET_STATUS) begin
            next_prdata = statusWord;
         end else if (paddr == OFFSET_CTRL) begin
            next_prdata = {31'h0000_0000, modeHold};
         end else begin
            next_prdata = 32'h0000_0000;
         end
      end
      if (psel && penable && pwrite && (paddr == OFFSET_CTRL)) begin
         next_modeHold = pwdata[POS_MODE_HOLD];
      end
   end

   // Register bus state
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
         modeHold <= RST_MODE_HOLD;
      end else begin
         prdata <= next_prdata;
         modeHold <= next_modeHold;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   chk_vco_select: assert property (
      configValid |-> vcoMultiplier == ((ratioCode == CODE_X8) ? VCO_X8 : VCO_X2))
      else $error("VCO multiplier does not match ratio code");

   chk_ratio_range: assert property (
      configValid && !coreClockStop |-> ratioHalf >= HALF_1_TO_1 && ratioHalf <= HALF_MAX)
      else $error("Core ratio outside 1:1 to 7:1");

   chk_bypass_mode: assert property (
      state == DECODE && ratioSync == CODE_BYPASS
      |=> pllBypass && !pllEnable && busOneToOne && ratioHalf == HALF_1_TO_1)
      else $error("Bypass code did not bypass the PLL at 1:1");

   chk_supply_input: assert property (
      state == DECODE && lowSample[0] && inputSync |=> !hysteresisOn && coreClockOutputEnable)
      else $error("Supply strap gave wrong input mode");

   chk_ground_input: assert property (
      state == DECODE && !lowSample[0] && !inputSync |=> hysteresisOn && !coreClockOutputEnable)
      else $error("Ground strap gave wrong input mode");

   chk_reset_input: assert property (
      state == DECODE && !lowSample[0] && inputSync |=> hysteresisOn && coreClockOutputEnable)
      else $error("Reset-wired strap gave wrong input mode");

   chk_inverse_input: assert property (
      state == DECODE && lowSample[0] && !inputSync |=> !hysteresisOn && !coreClockOutputEnable)
      else $error("Inverse-reset strap gave wrong input mode");

   chk_fast_output: assert property (
      state == DECODE && !lowSample[1] |=> fastOutputMode)
      else $error("Fast-output mode not selected");

   chk_compat_output: assert property (
      state == DECODE && lowSample[1] |=> !fastOutputMode)
      else $error("Compatibility timing not kept");

   chk_release_decode: assert property (
      state == SAMPLE_LOW && hardResetSyncN |=> state == DECODE ##1 configValid)
      else $error("Release of hard reset did not decode straps");

   chk_clock_off: assert property (
      configValid && ratioCode == CODE_CLOCK_OFF |-> coreClockStop && !pllEnable)
      else $error("Clock-off code did not stop the core clock");

endmodule

// ### board_strap_model.sv
// Board strap wiring and system hard reset source
`timescale 1ns/1ps
module board_strap_model (
   input wire logic mclk,
   input wire logic startFrame,
   input wire logic [3:0] ratioCode,
   input wire logic [1:0] inputWiring,
   input wire logic [1:0] outputWiring,
   output logic [3:0] ratioStrap,
   output logic inputModeStrap,
   output logic outputModeStrap,
   output logic hardResetN
);
   logic [3:0] lowCount = 4'h0;
   // Pin level per wiring: 0 supply, 1 ground, 2 hard reset, 3 inverted hard reset
   function automatic logic strapLevel(input logic [1:0] w, input logic h);
      return (w == 2'h0) ? 1'b1 : (w == 2'h1) ? 1'b0 : (w == 2'h2) ? h : ~h;
   endfunction
   // ----------------------------------------
   // Hard reset frame, eight cycles low
   // ----------------------------------------
   initial hardResetN = 1'b1;
   always @(posedge mclk) begin
      if (startFrame) begin
         hardResetN <= 1'b0;
         lowCount <= 4'h8;
      end else if (lowCount != 4'h0) begin
         lowCount <= lowCount - 4'h1;
         if (lowCount == 4'h1) hardResetN <= 1'b1;
      end
   end
   // Board picks only supported ratio codes, held stable across the frame
   assign ratioStrap = ratioCode;
   assign inputModeStrap = strapLevel(inputWiring, hardResetN);
   assign outputModeStrap = strapLevel(outputWiring, hardResetN);
endmodule

// ### clock_and_strap_mode_select_bench.sv
// Self-checking bench for the strap decoding clock control block
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin failures++; $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module clock_and_strap_mode_select_bench;
   import clock_strap_pkg::*;
   logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, startFrame = 1'b0, hardResetN, inputModeStrap, outputModeStrap;
   logic [3:0] ratioCode = 4'h0, ratioStrap, ratioHalf, vcoMultiplier;
   logic [1:0] inW = 2'h0, outW = 2'h0;
   logic pllEnable, pllBypass, busOneToOne, coreClockStop, hysteresisOn, coreClockOutputEnable;
   logic fastOutputMode, configValid;
   int failures = 0, comparisons = 0;
   // Rows: ratio code beside its ratio in half steps
   logic [7:0] rows [16] = '{8'h02, 8'h12, 8'hC3, 8'h44, 8'h65, 8'h86, 8'hE7, 8'hA8,
                             8'h79, 8'hBA, 8'h9B, 8'hDC, 8'h5D, 8'h2E, 8'h32, 8'hF0};
   always #5 mclk = ~mclk;
   clock_strap_select i_clock_strap_select (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ratioStrap(ratioStrap),
      .inputModeStrap(inputModeStrap), .outputModeStrap(outputModeStrap),
      .hardResetN(hardResetN), .ratioHalf(ratioHalf), .vcoMultiplier(vcoMultiplier),
      .pllEnable(pllEnable), .pllBypass(pllBypass), .busOneToOne(busOneToOne),
      .coreClockStop(coreClockStop), .hysteresisOn(hysteresisOn),
      .coreClockOutputEnable(coreClockOutputEnable), .fastOutputMode(fastOutputMode),
      .configValid(configValid));
   board_strap_model i_board_strap_model (.mclk(mclk), .startFrame(startFrame),
      .ratioCode(ratioCode), .inputWiring(inW), .outputWiring(outW), .ratioStrap(ratioStrap),
      .inputModeStrap(inputModeStrap), .outputModeStrap(outputModeStrap),
      .hardResetN(hardResetN));
   // APB transfer: setup, then access until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // One hard reset frame, then the decode latency settles
   task automatic frame(input logic [3:0] c, input logic [1:0] iw, input logic [1:0] ow);
      ratioCode <= c;
      inW <= iw;
      outW <= ow;
      startFrame <= 1'b1;
      @(posedge mclk);
      startFrame <= 1'b0;
      repeat (18) @(posedge mclk);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      // ----------------------------------------
      // All ratio codes, all sixteen wiring pairs
      // ----------------------------------------
      for (int i = 0; i < 16; i++) begin
         frame(rows[i][7:4], 2'(i % 4), 2'(i / 4));
         `CHECK("ratioHalf", rows[i][3:0], ratioHalf)
         `CHECK("vco", (rows[i][7:4] == CODE_X8) ? VCO_X8 : VCO_X2, vcoMultiplier)
         `CHECK("bypass", rows[i][7:4] == CODE_BYPASS, pllBypass)
         `CHECK("bus1to1", rows[i][7:4] == CODE_BYPASS, busOneToOne)
         `CHECK("stop", rows[i][7:4] == CODE_CLOCK_OFF, coreClockStop)
         `CHECK("pllEn", rows[i][7:4] != CODE_BYPASS && rows[i][7:4] != CODE_CLOCK_OFF,
                pllEnable)
         `CHECK("hyst", (i % 4 == 1) || (i % 4 == 2), hysteresisOn)
         `CHECK("clkOutEn", (i % 4 == 0) || (i % 4 == 2), coreClockOutputEnable)
         `CHECK("fastOut", (i / 4 == 1) || (i / 4 == 2), fastOutputMode)
         `CHECK("valid", 1'b1, configValid)
      end
      $display("test decode table done");
      // Mid-run reset returns the default mode
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHECK("rstHyst", 1'b0, hysteresisOn)
      `CHECK("rstClkOut", 1'b1, coreClockOutputEnable)
      `CHECK("rstFast", 1'b0, fastOutputMode)
      `CHECK("rstValid", 1'b0, configValid)
      resetn <= 1'b1;
      @(posedge mclk);
      $display("test reset done");
      // Status readback and an unmapped address
      frame(4'h8, 2'h2, 2'h1);
      apb(1'b0, OFFSET_STATUS, 32'h0);
      `CHECK("status", 32'h0003C268, rd)
      apb(1'b0, 12'h008, 32'h0);
      `CHECK("unmappedErr", 1'b1, err)
      `CHECK("unmappedData", 32'h0, rd)
      $display("test register access done");
      // Held configuration ignores a new frame, then follows once released
      apb(1'b1, OFFSET_CTRL, 32'h1);
      apb(1'b0, OFFSET_CTRL, 32'h0);
      `CHECK("holdBit", 32'h1, rd)
      frame(4'h2, 2'h0, 2'h0);
      `CHECK("heldRatio", 4'h6, ratioHalf)
      `CHECK("heldHyst", 1'b1, hysteresisOn)
      apb(1'b1, OFFSET_CTRL, 32'h0);
      frame(4'h2, 2'h0, 2'h0);
      `CHECK("freeRatio", HALF_MAX, ratioHalf)
      `CHECK("freeHyst", 1'b0, hysteresisOn)
      `CHECK("freeFast", 1'b0, fastOutputMode)
      $display("test mode hold done");
      report_and_stop();
   end
endmodule
